// *** pcc_clock_source.sv ***
// Clock source routing and loop configuration registers with oscillator divider
//
// Function
// - Power field 01 off, 00 running
// - Bypass bit skips oscillator divider
// - Select 0 routes external clock input
// - Select 1 routes internal oscillator
// - Reset: powered down, divide two, external
// - Oscillator divider ratios one through six
// - External loop oscillator: internal oscillator off
// - Polarity bit swaps pump direction in normal mode
// - Detector compares reference and feedback phases
// - Two-bit field sets anti-backlash width
// - Four pump modes: float, normal, up, down
// - Eight equal current steps 0.6-4.8 mA
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_clock_source (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [`PCC_ADDR_W-1:0] regAddr,
   input  wire logic [7:0]             regWrData,
   input  wire logic                   regWrEn,
   input  wire logic                   regRdEn,
   output logic      [7:0]             regRdData,
   input  wire logic                   extClkTick,
   input  wire logic                   vcoTick,
   input  wire logic                   refTick,
   input  wire logic                   fbTick,
   output logic                        distTick,
   output logic                        prescalerTick,
   output logic                        pllPowerDown,
   output logic                        vcoPowerOn,
   output logic                        pumpUp,
   output logic                        pumpDown,
   output logic                        pumpHighZ,
   output logic      [2:0]             pumpCurrentCode,
   output logic      [12:0]            pumpCurrentUa
);

   // ---------------------------------------------------------------
   // Functions
   // ---------------------------------------------------------------

   // Divider code to ratio; 000 is divide by two after reset
   function automatic logic [2:0] divRatio(input logic [2:0] code);
      logic [2:0] r;
      r = 3'h1;
      case (code)
         3'h0: r = 3'h2;
         3'h1: r = 3'h3;
         3'h2: r = 3'h4;
         3'h3: r = 3'h5;
         3'h4: r = 3'h6;
         default: r = 3'h1; // Remaining codes pass the source straight
      endcase
      return r;
   endfunction

   // Nominal pump current in microamps for a step code
   function automatic logic [12:0] stepCurrent(input logic [2:0] code);
      logic [12:0] steps;
      steps = {10'h000, code} + 13'h0001;
      return 13'(steps * `PCC_CP_STEP_UA);
   endfunction

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic [7:0] pllCtrlReg,  pllCtrlNext;  // Power, pump mode, current, polarity
   logic [7:0] abWidthReg,  abWidthNext;  // Anti-backlash width
   logic [7:0] oscDivReg,   oscDivNext;   // Oscillator divider code
   logic [7:0] srcRouteReg, srcRouteNext; // Bypass and source select
   logic [7:0] rdDataReg,   rdDataNext;   // Read answer

   // Next-state of register file: writes land at printed offsets,
   // undefined bits are masked so they read back as zero
   always_comb begin
      pllCtrlNext  = pllCtrlReg;
      abWidthNext  = abWidthReg;
      oscDivNext   = oscDivReg;
      srcRouteNext = srcRouteReg;
      rdDataNext   = rdDataReg;
      if (regWrEn) begin
         case (regAddr)
            `PCC_OFF_PLL_CTRL:  pllCtrlNext  = regWrData & `PCC_MASK_PLL_CTRL;
            `PCC_OFF_AB_WIDTH:  abWidthNext  = regWrData & `PCC_MASK_AB_WIDTH;
            `PCC_OFF_OSC_DIV:   oscDivNext   = regWrData & `PCC_MASK_OSC_DIV;
            `PCC_OFF_SRC_ROUTE: srcRouteNext = regWrData & `PCC_MASK_SRC_ROUTE;
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end
      if (regRdEn) begin
         case (regAddr)
            `PCC_OFF_PLL_CTRL:  rdDataNext = pllCtrlReg;
            `PCC_OFF_AB_WIDTH:  rdDataNext = abWidthReg;
            `PCC_OFF_OSC_DIV:   rdDataNext = oscDivReg;
            `PCC_OFF_SRC_ROUTE: rdDataNext = srcRouteReg;
            default:            rdDataNext = 8'h00; // Unmapped reads zero
         endcase
      end
   end

   // Register file storage; defaults restored on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         pllCtrlReg  <= `PCC_RST_PLL_CTRL;
         abWidthReg  <= `PCC_RST_AB_WIDTH;
         oscDivReg   <= `PCC_RST_OSC_DIV;
         srcRouteReg <= `PCC_RST_SRC_ROUTE;
         rdDataReg   <= 8'h00;
      end else begin
         pllCtrlReg  <= pllCtrlNext;
         abWidthReg  <= abWidthNext;
         oscDivReg   <= oscDivNext;
         srcRouteReg <= srcRouteNext;
         rdDataReg   <= rdDataNext;
      end
   end

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   logic       pllOn;      // Loop running
   logic       selVco;     // Internal oscillator chosen
   logic       bypassDiv;  // Divider skipped
   logic [2:0] ratio;      // Active divide ratio

   // Only code 00 runs the loop; 01 and the spare codes power it down,
   // the safe reading for codes with no defined meaning
   assign pllOn     = (pllCtrlReg[`PCC_PWR_MSB:`PCC_PWR_LSB] == `PCC_PWR_NORMAL);
   assign selVco    = srcRouteReg[`PCC_SEL_BIT];
   assign bypassDiv = srcRouteReg[`PCC_BYP_BIT];
   assign ratio     = divRatio(oscDivReg[`PCC_DIV_MSB:`PCC_DIV_LSB]);

   // ---------------------------------------------------------------
   // Source routing and oscillator divider
   // ---------------------------------------------------------------
   logic       srcTick;                // Selected source edge
   logic [2:0] divCntReg, divCntNext;  // Source edges since last output
   logic       distNext;               // Next distribution edge
   logic       preNext;                // Next prescaler edge
   logic       vcoOnNext;              // Next oscillator power state

   // Source mux: external input for 0, internal oscillator for 1
   always_comb begin
      if (selVco) begin
         srcTick = vcoTick;
      end else begin
         srcTick = extClkTick;
      end
   end

   // Divider and bypass; a ratio change restarts from the next edge
   // rather than glitching, at the cost of one irregular period
   always_comb begin
      divCntNext = divCntReg;
      distNext   = 1'b0;
      if (bypassDiv) begin
         distNext   = srcTick;
         divCntNext = 3'h0;
      end else if (srcTick) begin
         if (divCntReg >= ratio - 3'h1) begin
            distNext   = 1'b1;
            divCntNext = 3'h0;
         end else begin
            divCntNext = divCntReg + 3'h1;
         end
      end
      // Internal oscillator powered only when chosen with loop on;
      // with an external oscillator its edges go straight to the
      // prescaler
      vcoOnNext = pllOn & selVco;
      preNext   = pllOn & srcTick;
   end

   // Divider and routing registers
   always_ff @(posedge clk) begin
      if (reset) begin
         divCntReg     <= 3'h0;
         distTick      <= 1'b0;
         prescalerTick <= 1'b0;
         vcoPowerOn    <= 1'b0;
         pllPowerDown  <= 1'b1;
      end else begin
         divCntReg     <= divCntNext;
         distTick      <= distNext;
         prescalerTick <= preNext;
         vcoPowerOn    <= vcoOnNext;
         pllPowerDown  <= ~pllOn;
      end
   end

   // ---------------------------------------------------------------
   // Charge pump current step
   // ---------------------------------------------------------------
   logic [2:0]  curCodeNext; // Step code from register
   logic [12:0] curUaNext;   // Nominal microamps

   // Eight equal steps of one LSB current each
   always_comb begin
      curCodeNext = pllCtrlReg[`PCC_CUR_MSB:`PCC_CUR_LSB];
      curUaNext   = stepCurrent(curCodeNext);
   end

   // Current step registers
   always_ff @(posedge clk) begin
      if (reset) begin
         pumpCurrentCode <= 3'h0;
         pumpCurrentUa   <= `PCC_CP_STEP_UA;
      end else begin
         pumpCurrentCode <= curCodeNext;
         pumpCurrentUa   <= curUaNext;
      end
   end

   // ---------------------------------------------------------------
   // Phase detector and charge pump control
   // ---------------------------------------------------------------
   pcc_ctrl_if ctrl ();

   // Held fields steer the detector continuously
   assign ctrl.pllOn       = pllOn;
   assign ctrl.polarityNeg = pllCtrlReg[`PCC_POL_BIT];
   assign ctrl.pumpMode    =
      pcc_pkg::pcc_pump_mode_type'(pllCtrlReg[`PCC_MODE_MSB:`PCC_MODE_LSB]);
   assign ctrl.abWidth     = abWidthReg[`PCC_AB_MSB:`PCC_AB_LSB];

   pcc_phase_detector detector (
      .clk     (clk),
      .reset   (reset),
      .refTick (refTick),
      .fbTick  (fbTick),
      .ctrl    (ctrl.pump)
   );

   // Pump commands come from the detector's own flip-flops
   assign pumpUp    = ctrl.pumpUp;
   assign pumpDown  = ctrl.pumpDown;
   assign pumpHighZ = ctrl.pumpHighZ;
   assign regRdData = rdDataReg;

endmodule

// *** pcc_params.svh ***
// Register offsets, field positions, reset values and counts for the clock source block
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (10-bit register port address)
// ---------------------------------------------------------------
`define PCC_ADDR_W          10
`define PCC_OFF_PLL_CTRL    10'h010
`define PCC_OFF_AB_WIDTH    10'h017
`define PCC_OFF_OSC_DIV     10'h1e0
`define PCC_OFF_SRC_ROUTE   10'h1e1

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define PCC_PWR_LSB         0
`define PCC_PWR_MSB         1
`define PCC_MODE_LSB        2
`define PCC_MODE_MSB        3
`define PCC_CUR_LSB         4
`define PCC_CUR_MSB         6
`define PCC_POL_BIT         7
`define PCC_AB_LSB          0
`define PCC_AB_MSB          1
`define PCC_DIV_LSB         0
`define PCC_DIV_MSB         2
`define PCC_BYP_BIT         0
`define PCC_SEL_BIT         1

// ---------------------------------------------------------------
// Field encodings and reset values
// ---------------------------------------------------------------
`define PCC_PWR_NORMAL      2'h0
`define PCC_PWR_DOWN        2'h1
`define PCC_RST_PLL_CTRL    8'h01
`define PCC_RST_AB_WIDTH    8'h00
`define PCC_RST_OSC_DIV     8'h00
`define PCC_RST_SRC_ROUTE   8'h00
`define PCC_MASK_PLL_CTRL   8'hff
`define PCC_MASK_AB_WIDTH   8'h03
`define PCC_MASK_OSC_DIV    8'h07
`define PCC_MASK_SRC_ROUTE  8'h03

// ---------------------------------------------------------------
// Charge pump current steps and detector timing
// ---------------------------------------------------------------
`define PCC_CP_STEP_UA      13'h258
`define PCC_AB_CNT_W        3

`endif

// *** pcc_pkg.sv ***
// Types shared by the clock source configuration block
package pcc_pkg;

   // Charge pump operating modes
   typedef enum logic [1:0] {
      PCC_CP_HIGHZ = 2'h0,
      PCC_CP_UP    = 2'h1,
      PCC_CP_DOWN  = 2'h2,
      PCC_CP_NORM  = 2'h3
   } pcc_pump_mode_type;

endpackage

// *** pcc_ctrl_if.sv ***
// Control bundle between the register file and the phase detector
`timescale 1ns/1ps
interface pcc_ctrl_if;
   logic                       pllOn;       // Loop powered
   logic                       polarityNeg; // Negative tuning slope
   pcc_pkg::pcc_pump_mode_type pumpMode;    // Charge pump mode
   logic [1:0]                 abWidth;     // Anti-backlash width code
   logic                       pumpUp;      // Pump-up command
   logic                       pumpDown;    // Pump-down command
   logic                       pumpHighZ;   // Pump output floating

   modport cfg  (output pllOn, polarityNeg, pumpMode, abWidth,
                 input  pumpUp, pumpDown, pumpHighZ);
   modport pump (input  pllOn, polarityNeg, pumpMode, abWidth,
                 output pumpUp, pumpDown, pumpHighZ);
endinterface

// *** pcc_phase_detector.sv ***
// Phase frequency detector with anti-backlash timing and charge pump mode control
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_phase_detector (
   input  wire logic  clk,
   input  wire logic  reset,
   input  wire logic  refTick,   // Reference divider output pulse
   input  wire logic  fbTick,    // Feedback divider output pulse
   pcc_ctrl_if.pump   ctrl
);

   // ---------------------------------------------------------------
   // Detector state
   // ---------------------------------------------------------------
   logic                     upReg, upNext;       // Reference ahead
   logic                     dnReg, dnNext;       // Feedback ahead
   logic [`PCC_AB_CNT_W-1:0] abCntReg, abCntNext; // Overlap timer
   logic                     pUpReg, pUpNext;     // Registered pump commands
   logic                     pDnReg, pDnNext;
   logic                     hzReg, hzNext;

   // Next-state: classic tri-state detector; both flags held for the
   // anti-backlash time before reset, so tiny errors still produce pulses
   always_comb begin
      upNext    = upReg | refTick;
      dnNext    = dnReg | fbTick;
      abCntNext = '0;
      if (upReg && dnReg) begin
         abCntNext = abCntReg + 1'b1;
         // Overlap lasts width code plus one cycles
         if (abCntReg == {1'b0, ctrl.abWidth}) begin
            upNext    = refTick;
            dnNext    = fbTick;
            abCntNext = '0;
         end
      end
      if (!ctrl.pllOn) begin
         // Powered-down loop keeps the detector idle
         upNext    = 1'b0;
         dnNext    = 1'b0;
         abCntNext = '0;
      end
      // Mode and polarity select the pump drive
      pUpNext = 1'b0;
      pDnNext = 1'b0;
      hzNext  = 1'b0;
      case (ctrl.pumpMode)
         pcc_pkg::PCC_CP_HIGHZ: begin
            hzNext = 1'b1;
         end
         pcc_pkg::PCC_CP_UP: begin
            pUpNext = 1'b1;
         end
         pcc_pkg::PCC_CP_DOWN: begin
            pDnNext = 1'b1;
         end
         pcc_pkg::PCC_CP_NORM: begin
            // Negative slope swaps the pump direction
            pUpNext = ctrl.polarityNeg ? dnReg : upReg;
            pDnNext = ctrl.polarityNeg ? upReg : dnReg;
         end
         default: begin
            hzNext = 1'b1;
         end
      endcase
      if (!ctrl.pllOn) begin
         pUpNext = 1'b0;
         pDnNext = 1'b0;
         hzNext  = 1'b1;
      end
   end

   // Registers only
   always_ff @(posedge clk) begin
      if (reset) begin
         upReg    <= 1'b0;
         dnReg    <= 1'b0;
         abCntReg <= '0;
         pUpReg   <= 1'b0;
         pDnReg   <= 1'b0;
         hzReg    <= 1'b1;
      end else begin
         upReg    <= upNext;
         dnReg    <= dnNext;
         abCntReg <= abCntNext;
         pUpReg   <= pUpNext;
         pDnReg   <= pDnNext;
         hzReg    <= hzNext;
      end
   end

   assign ctrl.pumpUp    = pUpReg;
   assign ctrl.pumpDown  = pDnReg;
   assign ctrl.pumpHighZ = hzReg;

endmodule

// *** pcc_clock_source_assertions.sv ***
// Port-level concurrent checks for the clock source configuration block
`timescale 1ns/1ps
`include "pcc_params.svh"
module pcc_clock_source_assertions (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic [`PCC_ADDR_W-1:0] regAddr,
   input wire logic [7:0]             regWrData,
   input wire logic                   regWrEn,
   input wire logic                   regRdEn,
   input wire logic [7:0]             regRdData,
   input wire logic                   extClkTick,
   input wire logic                   vcoTick,
   input wire logic                   distTick,
   input wire logic                   prescalerTick,
   input wire logic                   pllPowerDown,
   input wire logic                   vcoPowerOn,
   input wire logic                   pumpUp,
   input wire logic                   pumpDown,
   input wire logic                   pumpHighZ,
   input wire logic [2:0]             pumpCurrentCode,
   input wire logic [12:0]            pumpCurrentUa
);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // Write then read of the width field on the next cycle
   sequence sAbWrite;
      regWrEn && regAddr == `PCC_OFF_AB_WIDTH;
   endsequence
   sequence sAbRead;
      regRdEn && !regWrEn && regAddr == `PCC_OFF_AB_WIDTH;
   endsequence

   // Reset itself is the cause here, so the default disable is lifted
   a_reset_defaults: assert property (disable iff (1'b0) reset |=> pllPowerDown && pumpHighZ
      && !vcoPowerOn && !pumpUp && !pumpDown && !distTick && pumpCurrentUa == 13'h258)
      else $error("outputs not at defaults after reset");
   a_current_steps: assert property (pumpCurrentUa == (13'(pumpCurrentCode) + 13'h1) * 13'h258)
      else $error("pump current not matching its step code");
   a_dist_cause: assert property (distTick |-> $past(extClkTick || vcoTick))
      else $error("distribution pulse without a source pulse");
   a_read_hold: assert property (!$past(regRdEn) && !$past(reset) |-> $stable(regRdData))
      else $error("read answer changed without a read");
   a_unmapped_zero: assert property (regRdEn && !(regAddr inside {`PCC_OFF_PLL_CTRL,
      `PCC_OFF_AB_WIDTH, `PCC_OFF_OSC_DIV, `PCC_OFF_SRC_ROUTE}) |=> regRdData == 8'h00)
      else $error("unmapped read not zero");
   a_ab_readback: assert property (sAbWrite ##1 sAbRead |=>
      regRdData == ($past(regWrData, 2) & 8'h03)) else $error("width field readback wrong");
   a_float_when_off: assert property (pllPowerDown [*3] |-> pumpHighZ && !pumpUp && !pumpDown)
      else $error("pump active while loop powered down");
   a_highz_quiet: assert property (pumpHighZ |-> !pumpUp && !pumpDown)
      else $error("pump command while floating");
   a_prescaler_off: assert property (pllPowerDown [*3] |-> !prescalerTick)
      else $error("prescaler pulse while loop powered down");
endmodule

bind pcc_clock_source pcc_clock_source_assertions i_chk (.clk, .reset, .regAddr, .regWrData,
   .regWrEn, .regRdEn, .regRdData, .extClkTick, .vcoTick, .distTick, .prescalerTick,
   .pllPowerDown, .vcoPowerOn, .pumpUp, .pumpDown, .pumpHighZ, .pumpCurrentCode, .pumpCurrentUa);

// *** test_pcc_clock_source.sv ***
// Self-checking bench for the clock source configuration block
`timescale 1ns/1ps
module test_pcc_clock_source;
   logic        clk, reset, regWrEn, regRdEn, extClkTick, vcoTick, refTick, fbTick;
   logic [9:0]  regAddr;
   logic [7:0]  regWrData, regRdData;
   logic        distTick, prescalerTick, pllPowerDown, vcoPowerOn;
   logic        pumpUp, pumpDown, pumpHighZ;
   logic [2:0]  pumpCurrentCode;
   logic [12:0] pumpCurrentUa;
   logic [7:0]  expQ[$];        // Expected read answers, oldest first
   logic        rdLaunch = 1'b0; // Read taken at the last edge
   int          miscompares = 0;
   int          comparisons = 0;
   int          distCnt = 0;    // Distribution pulses seen
   int          preCnt = 0;     // Prescaler pulses seen
   logic [31:0] seed;           // Xorshift state

   pcc_clock_source i_dut (.clk, .reset, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
      .extClkTick, .vcoTick, .refTick, .fbTick, .distTick, .prescalerTick, .pllPowerDown,
      .vcoPowerOn, .pumpUp, .pumpDown, .pumpHighZ, .pumpCurrentCode, .pumpCurrentUa);

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [12:0] got, input logic [12:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic summarize();
      $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Write, then read back on the very next cycle
   task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
      @(posedge clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge clk);
      regWrEn   <= 1'b0;
      regRdEn   <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRdEn   <= 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      expQ.push_back(e);
      @(posedge clk);
      regRdEn <= 1'b0;
   endtask

   // Back-to-back pulses on one source, random noise on the other
   task automatic ticks(input int n, input bit useVco);
      repeat (n) begin
         @(posedge clk);
         seed = xs(seed);
         extClkTick <= useVco ? seed[0] : 1'b1;
         vcoTick    <= useVco ? 1'b1 : seed[0];
      end
      @(posedge clk);
      extClkTick <= 1'b0;
      vcoTick    <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask

   // One detector input pulse; long wait covers the widest overlap
   // and keeps the detector rate low for any width code
   task automatic pulse(input bit fb);
      @(posedge clk);
      refTick <= ~fb;
      fbTick  <= fb;
      @(posedge clk);
      refTick <= 1'b0;
      fbTick  <= 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask

   // ---------------------------------------------
   // Monitor: answers are settled by the falling edge
   // ---------------------------------------------
   always @(posedge clk) begin
      rdLaunch <= regRdEn & ~reset;
      if (distTick === 1'b1)
         distCnt++;
      if (prescalerTick === 1'b1)
         preCnt++;
   end

   always @(negedge clk) begin
      if (rdLaunch === 1'b1) begin
         if (expQ.size() == 0)
            chk(13'h1, 13'h0, "read answer with no note");
         else
            chk(13'(regRdData), 13'(expQ.pop_front()), "read data");
      end
   end

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      repeat (100000) @(posedge clk);
      $display("MISMATCH t=%0t run did not finish", $time);
      miscompares++;
      summarize();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {reset, regWrEn, regRdEn, extClkTick, vcoTick, refTick, fbTick} = 7'h40;
      regAddr   = 10'h000;
      regWrData = 8'h00;
      seed      = 32'd62;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk(13'(pllPowerDown), 13'h1, "power-down default");
      chk(13'(pumpHighZ), 13'h1, "pump floating default");
      chk(13'(vcoPowerOn), 13'h0, "oscillator off default");
      rd(10'h010, 8'h01);
      rd(10'h017, 8'h00);
      rd(10'h1e0, 8'h00);
      rd(10'h1e1, 8'h00);
      seed = xs(seed);
      wr(10'h017, seed[7:0], seed[7:0] & 8'h03);
      wr(10'h011, seed[15:8], 8'h00);
      // Every divider code; bypass toggle restarts the count
      for (int c = 0; c < 8; c++) begin
         wr(10'h1e0, {5'h1f, c[2:0]}, {5'h00, c[2:0]});
         wr(10'h1e1, 8'h01, 8'h01);
         wr(10'h1e1, 8'h00, 8'h00);
         @(negedge clk);
         distCnt = 0;
         ticks(60, 1'b0);
         chk(13'(distCnt), 13'(60 / (c < 5 ? c + 2 : 1)), "divided pulses");
      end
      chk(13'(preCnt), 13'h0, "prescaler idle, loop off");
      // Bypass with each source, back-to-back pulses on it; other ignored
      for (int s = 0; s < 2; s++) begin
         wr(10'h1e1, {6'h3f, s[0], 1'b1}, {6'h00, s[0], 1'b1});
         @(negedge clk);
         distCnt = 0;
         ticks(20, s[0]);
         chk(13'(distCnt), 13'd20, "bypass pulses");
      end
      // Loop on with the external oscillator
      wr(10'h1e1, 8'h01, 8'h01);
      wr(10'h010, 8'h7c, 8'h7c);
      @(negedge clk);
      chk(13'(pllPowerDown), 13'h0, "loop running");
      chk(13'(vcoPowerOn), 13'h0, "oscillator off for external");
      preCnt = 0;
      ticks(10, 1'b0);
      chk(13'(preCnt), 13'd10, "prescaler pulses");
      for (int k = 0; k < 8; k++) begin
         wr(10'h010, {1'b0, k[2:0], 4'hc}, {1'b0, k[2:0], 4'hc});
         @(negedge clk);
         chk(13'(pumpCurrentCode), 13'(k), "current code");
         chk(pumpCurrentUa, 13'((k + 1) * 600), "current value");
      end
      // Normal mode, both polarities, external oscillator still chosen
      for (int p = 0; p < 2; p++) begin
         wr(10'h010, {p[0], 7'h0c}, {p[0], 7'h0c});
         pulse(1'b0);
         chk(13'({pumpUp, pumpDown, pumpHighZ}), 13'(p == 0 ? 4 : 2), "reference lead");
         pulse(1'b1);
         chk(13'({pumpUp, pumpDown}), 13'h0, "idle after feedback");
      end
      // Floating, forced up, forced down
      for (int m = 0; m < 3; m++) begin
         wr(10'h010, 8'(m << 2), 8'(m << 2));
         @(negedge clk);
         chk(13'({pumpHighZ, pumpUp, pumpDown}), 13'(m == 0 ? 4 : 3 - m), "pump mode");
      end
      wr(10'h1e1, 8'h03, 8'h03);
      @(negedge clk);
      chk(13'(vcoPowerOn), 13'h1, "internal oscillator powered");
      wr(10'h010, 8'h0d, 8'h0d);
      repeat (3) @(negedge clk);
      chk(13'({pllPowerDown, pumpHighZ}), 13'h3, "loop off, pump floating");
      for (int i = 0; i < 20 && expQ.size() > 0; i++)
         @(posedge clk);
      if (expQ.size() != 0) begin
         miscompares++;
         $display("MISMATCH t=%0t reads left unanswered", $time);
      end
      summarize();
   end
endmodule
